// [tb/cpu_model.sv]
`timescale 1ns/1ns
module cpu_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cpuHold,
  input  wire logic        pcLoadStb,
  input  wire logic [15:0] pcLoad,
  input  wire logic        lowPower,
  input  wire logic        trapReq,
  input  wire logic        iretReq,
  output logic             insnEnd,
  output logic             trapInsn,
  output logic             iretInsn,
  output logic      [15:0] pcIn,
  output int               loads
);
  // ****************************************
  // instruction boundaries and special insns
  // ****************************************
  logic [1:0] phase;
  logic       trapPend;
  logic       iretPend;
  logic       boundary;

  assign boundary = (phase == 2'h3) && !cpuHold && !lowPower;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase    <= 2'h0;
      insnEnd  <= 1'b0;
      trapInsn <= 1'b0;
      iretInsn <= 1'b0;
    end else begin
      phase    <= phase + 2'h1;
      insnEnd  <= boundary;
      trapInsn <= boundary && trapPend;
      iretInsn <= boundary && !trapPend && iretPend;
    end
  end

  // trap only on bench command, which the top-level routine gives by pulsing trapReq
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trapPend <= 1'b0;
      iretPend <= 1'b0;
    end else begin
      if (boundary) trapPend <= 1'b0;
      if (trapReq) trapPend <= 1'b1;
      if (boundary && !trapPend) iretPend <= 1'b0;
      if (iretReq) iretPend <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pcIn  <= 16'h0000;
      loads <= 0;
    end else if (pcLoadStb) begin
      pcIn  <= pcLoad;
      loads <= loads + 1;
    end
  end
endmodule : cpu_model

// [tb/nested_priority_interrupt_ctrl_tb_top.sv]
`timescale 1ns/1ns
module nested_priority_interrupt_ctrl_tb_top;
  // ****************************************
  // design, partner and bus tasks
  // ****************************************
  logic        sysClk, rstN, read, write, waitrequest, insnEnd, trapInsn, iretInsn, haltMode, waitMode;
  logic        wdgFlag, cpuHold, pcLoadStb, ctxRestoreStb, wakeReq, trapReq, iretReq;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rdVal;
  logic [15:0] pcIn, pcLoad;
  logic [7:0]  xRestore, aRestore, ccOut, extPins;
  logic [13:0] periphFlag, periphClr;
  int          loads, badCount, numChecks, l0, restores;

  nested_priority_interrupt_ctrl dut_u (
    .sys_clk(sysClk), .rst_n(rstN), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .insnEnd(insnEnd), .trapInsn(trapInsn),
    .iretInsn(iretInsn), .haltMode(haltMode), .waitMode(waitMode), .pcIn(pcIn), .xIn(8'h5A), .aIn(8'hC3),
    .ccFlagsIn(8'h00), .wdgFlag(wdgFlag), .periphFlag(periphFlag), .periphClr(periphClr), .extPins(extPins),
    .cpuHold(cpuHold), .pcLoadStb(pcLoadStb), .pcLoad(pcLoad), .ctxRestoreStb(ctxRestoreStb),
    .xRestore(xRestore), .aRestore(aRestore), .ccOut(ccOut), .wakeReq(wakeReq));

  cpu_model partner_u (
    .sys_clk(sysClk), .rst_n(rstN), .cpuHold(cpuHold), .pcLoadStb(pcLoadStb), .pcLoad(pcLoad),
    .lowPower(haltMode | waitMode), .trapReq(trapReq), .iretReq(iretReq), .insnEnd(insnEnd),
    .trapInsn(trapInsn), .iretInsn(iretInsn), .pcIn(pcIn), .loads(loads));

  // count context restore strobes
  always_ff @(posedge sysClk) begin
    if (ctxRestoreStb) restores <= restores + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sysClk);
  endtask : cyc

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge sysClk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rdVal = readdata;
    if (n >= 50) chk(1'b0, 1'b1, "bus answer");
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge sysClk);
  endtask : bus

  task automatic rdChk(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    chk(rdVal, exp, nm);
  endtask : rdChk

  task automatic flag(input logic [13:0] m);
    periphFlag <= m;
    cyc(2);
    periphFlag <= 14'h0000;
    cyc(1);
  endtask : flag

  task automatic expLoad(input logic [15:0] v, input string nm);
    int n;
    int s;
    n = 0;
    s = loads;
    while (loads == s && n < 300) begin
      @(posedge sysClk);
      n++;
    end
    chk({16'h0, pcIn}, {16'h0, v}, nm);
    chk({31'h0, cpuHold}, 32'h0, "hold released");
  endtask : expLoad

  task automatic pair(input logic [1:0] exp);
    cyc(2);
    chk({ccOut[5], ccOut[3]}, exp, "pair");
  endtask : pair

  task automatic int_return_insn(input logic [15:0] v);
    int r0;
    r0 = restores;
    iretReq <= 1'b1;
    cyc(1);
    iretReq <= 1'b0;
    expLoad(v, "return pc");
    chk({xRestore, aRestore}, 16'h5AC3, "restored x a");
    chk(32'(restores - r0), 32'h1, "restore strobe");
  endtask : int_return_insn

  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    sysClk = 1'b0;
    forever #50 sysClk = ~sysClk;
  end

  initial begin
    #(100 * 20000);
    badCount++;
    conclude();
  end

  initial begin
    {rstN, read, write, haltMode, waitMode, wdgFlag, trapReq, iretReq} = 8'h00;
    {address, writedata, periphFlag, periphClr, extPins} = {5'h00, 32'h0, 14'h0, 14'h0, 8'hFF};
    cyc(20);
    rstN <= 1'b1;
    expLoad(16'hFFFE, "reset vector");
    pair(2'b11);
    for (int i = 1; i < 5; i++) rdChk(5'(4 * i), 32'hFF, "prio reset");
    bus(1'b1, 5'h04, 32'hCF);
    bus(1'b1, 5'h04, 32'h64);
    rdChk(5'h04, 32'h44, "prio keep");
    bus(1'b1, 5'h08, 32'hF7);
    bus(1'b1, 5'h0C, 32'hC7);
    bus(1'b1, 5'h10, 32'h04);
    rdChk(5'h10, 32'hF4, "prio3 upper");
    bus(1'b1, 5'h14, 32'h2624);
    bus(1'b1, 5'h1C, 32'h03);
    extPins <= 8'hFE;
    flag(14'h0A20);
    flag(14'h0400);
    periphClr <= 14'h0400;
    cyc(1);
    periphClr <= 14'h0000;
    rdChk(5'h18, 32'h224, "pending");
    bus(1'b1, 5'h00, 32'h20);
    expLoad(16'hFFF6, "ext vector");
    rdChk(5'h18, 32'h220, "ext cleared");
    int_return_insn(16'hFFFE);
    expLoad(16'hFFF0, "tie winner");
    pair(2'b01);
    rdChk(5'h18, 32'h200, "still pending");
    int_return_insn(16'hFFFE);
    expLoad(16'hFFE8, "latched later");
    trapReq <= 1'b1;
    cyc(1);
    trapReq <= 1'b0;
    expLoad(16'hFFFC, "trap vector");
    pair(2'b11);
    wdgFlag <= 1'b1;
    l0 = loads;
    cyc(30);
    chk(32'(loads), 32'(l0), "no preempt");
    rdChk(5'h18, 32'h1, "top pending");
    int_return_insn(16'hFFE8);
    expLoad(16'hFFFA, "top vector");
    int_return_insn(16'hFFE8);
    int_return_insn(16'hFFFE);
    haltMode <= 1'b1;
    flag(14'h0200);
    cyc(8);
    chk(wakeReq, 1'b0, "halt no wake");
    flag(14'h2000);
    cyc(8);
    chk(wakeReq, 1'b1, "halt wake");
    haltMode <= 1'b0;
    expLoad(16'hFFE0, "halt first");
    int_return_insn(16'hFFFE);
    expLoad(16'hFFE8, "after first");
    int_return_insn(16'hFFFE);
    waitMode <= 1'b1;
    flag(14'h0400);
    cyc(8);
    chk(wakeReq, 1'b1, "wait wake");
    waitMode <= 1'b0;
    expLoad(16'hFFE6, "wait served");
    int_return_insn(16'hFFFE);
    conclude();
  end
endmodule : nested_priority_interrupt_ctrl_tb_top

// [verilog/nested_priority_interrupt_ctrl.sv]
`timescale 1ns/1ns
module nested_priority_interrupt_ctrl import nic_pkg::*; #(
  parameter logic [NVEC-1:0] HALT_CAP = HALT_CAP_DEF,
  parameter int              SP_W     = 5
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic [4:0]      address,
  input  wire logic            read,
  input  wire logic            write,
  input  wire logic [31:0]     writedata,
  output logic      [31:0]     readdata,
  output logic                 waitrequest,
  input  wire logic            insnEnd,
  input  wire logic            trapInsn,
  input  wire logic            iretInsn,
  input  wire logic            haltMode,
  input  wire logic            waitMode,
  input  wire logic [15:0]     pcIn,
  input  wire logic [7:0]      xIn,
  input  wire logic [7:0]      aIn,
  input  wire logic [7:0]      ccFlagsIn,
  input  wire logic            wdgFlag,
  input  wire logic [NVEC-1:0] periphFlag,
  input  wire logic [NVEC-1:0] periphClr,
  input  wire logic [7:0]      extPins,
  output logic                 cpuHold,
  output logic                 pcLoadStb,
  output logic      [15:0]     pcLoad,
  output logic                 ctxRestoreStb,
  output logic      [7:0]      xRestore,
  output logic      [7:0]      aRestore,
  output logic      [7:0]      ccOut,
  output logic                 wakeReq
);

  // ****************************************
  // declarations
  // ****************************************
  seq_state_t      state;
  logic [2:0]      cnt;
  logic [1:0]      prioReg;
  logic [7:0]      isprReg [4];
  logic [NVEC-1:0] enReg;
  logic [NVEC-1:0] pendReg;
  logic [7:0]      extSelReg;
  logic            tliPend;
  logic            wdgPrev;
  logic [7:0]      extMeta;
  logic [7:0]      extSync;
  logic            extLine;
  logic            extPrev;
  logic            haltFirst;
  logic            trapActive;
  logic [3:0]      depthReg;
  logic [3:0]      trapDepth;
  logic [15:0]     svcVec;
  logic            svcNmi;
  logic [1:0]      svcPrio;
  logic [15:0]     ctxPc;
  logic [7:0]      ctxX;
  logic [7:0]      ctxA;
  logic [7:0]      ctxCc;
  logic [7:0]      ccPop;
  logic [7:0]      aPop;
  logic [7:0]      xPop;
  logic [7:0]      pchPop;
  logic [SP_W-1:0] spReg;
  logic [SP_W-1:0] spPlus;
  logic [7:0]      stackMem [2**SP_W];
  logic [7:0]      pushByte;
  logic [7:0]      ccCur;
  logic [1:0]      vecPair [NVEC];
  logic [2*NVEC-1:0] lvlFlat;
  logic [NVEC-1:0] eligAll;
  logic [NVEC-1:0] arbReq;
  logic [NVEC-1:0] setVec;
  logic [NVEC-1:0] takeOH;
  logic            arbFound;
  logic [3:0]      arbIdx;
  logic            run;
  logic            trapTake;
  logic            iretTake;
  logic            tliTake;
  logic            mskTake;
  logic            take;
  logic            wrEn;
  logic [31:0]     rdMux;

  // ****************************************
  // request gathering
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      extMeta <= 8'h00;
      extSync <= 8'h00;
      extPrev <= 1'b0;
      wdgPrev <= 1'b0;
    end else begin
      extMeta <= extPins;
      extSync <= extMeta;
      extPrev <= extLine;
      wdgPrev <= wdgFlag;
    end
  end

  assign extLine = ~&(extSync | ~extSelReg);

  always_comb begin
    setVec = periphFlag & enReg & MASKABLE;
    setVec[EXT_VEC] = setVec[EXT_VEC] | (extLine & ~extPrev & enReg[EXT_VEC]);
  end

  // set wins over clear
  assign takeOH = mskTake ? (NVEC'(1) << arbIdx) : '0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pendReg <= '0;
    end else begin
      pendReg <= (pendReg & ~(periphClr | takeOH)) | setVec;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tliPend <= 1'b0;
    end else if (wdgFlag && !wdgPrev) begin
      tliPend <= 1'b1;
    end else if (tliTake) begin
      tliPend <= 1'b0;
    end
  end

  // ****************************************
  // arbitration
  // ****************************************
  for (genvar i = 0; i < NVEC; i++) begin : g_pair
    assign vecPair[i] = isprReg[i/4][2*(i%4)+:2];
    assign lvlFlat[2*i+:2] = lvl_of(vecPair[i]);
    assign eligAll[i] = MASKABLE[i] && pendReg[i] && enReg[i]
                        && (lvl_of(vecPair[i]) > lvl_of(prioReg));
  end

  assign arbReq = haltFirst ? (eligAll & HALT_CAP) : eligAll;

  prio_arbiter #(
    .N (NVEC)
  ) u_arb (
    .req   (arbReq),
    .lvl   (lvlFlat),
    .found (arbFound),
    .idx   (arbIdx),
    .best  ()
  );

  assign run      = (state == ST_RUN) && insnEnd;
  assign trapTake = run && trapInsn;
  assign iretTake = run && iretInsn && !trapInsn;
  assign tliTake  = run && !trapInsn && !iretInsn && tliPend && !trapActive;
  assign mskTake  = run && !trapInsn && !iretInsn && !(tliPend && !trapActive) && arbFound;
  assign take     = trapTake || tliTake || mskTake;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      haltFirst <= 1'b0;
    end else if (take) begin
      haltFirst <= 1'b0;
    end else if (haltMode && (|(eligAll & HALT_CAP) || tliPend)) begin
      haltFirst <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= (waitMode && (|eligAll || tliPend))
                 || (haltMode && (|(eligAll & HALT_CAP) || tliPend));
    end
  end

  // ****************************************
  // nesting depth and trap tracking
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      depthReg   <= 4'h0;
      trapDepth  <= 4'h0;
      trapActive <= 1'b0;
    end else if (take) begin
      depthReg <= depthReg + 4'h1;
      if (trapTake) begin
        trapActive <= 1'b1;
        trapDepth  <= depthReg + 4'h1;
      end
    end else if (iretTake) begin
      depthReg <= depthReg - 4'h1;
      if (depthReg == trapDepth) begin
        trapActive <= 1'b0;
      end
    end
  end

  // ****************************************
  // service capture
  // ****************************************
  always_comb begin
    ccCur = ccFlagsIn;
    ccCur[PRIO_HI_BIT] = prioReg[1];
    ccCur[PRIO_LO_BIT] = prioReg[0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      svcVec  <= VEC_RESET;
      svcNmi  <= 1'b1;
      svcPrio <= LVL3_CODE;
      ctxPc   <= 16'h0000;
      ctxX    <= 8'h00;
      ctxA    <= 8'h00;
      ctxCc   <= 8'h00;
    end else if (take) begin
      svcVec  <= trapTake ? VEC_TRAP : tliTake ? VEC_BASE
                 : VEC_BASE - {11'h000, arbIdx, 1'b0};
      svcNmi  <= trapTake || tliTake;
      svcPrio <= vecPair[arbIdx];
      ctxPc   <= pcIn;
      ctxX    <= xIn;
      ctxA    <= aIn;
      ctxCc   <= ccCur;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state         <= ST_RESET;
      cnt           <= 3'h0;
      cpuHold       <= 1'b1;
      pcLoadStb     <= 1'b0;
      pcLoad        <= 16'h0000;
      ctxRestoreStb <= 1'b0;
      xRestore      <= 8'h00;
      aRestore      <= 8'h00;
    end else begin
      pcLoadStb     <= 1'b0;
      ctxRestoreStb <= 1'b0;
      unique case (state)
        ST_RESET: begin
          pcLoad    <= VEC_RESET;
          pcLoadStb <= 1'b1;
          cpuHold   <= 1'b0;
          state     <= ST_RUN;
        end
        ST_RUN: begin
          cnt <= 3'h0;
          if (take) begin
            cpuHold <= 1'b1;
            state   <= ST_PUSH;
          end else if (iretTake) begin
            cpuHold <= 1'b1;
            state   <= ST_POP;
          end
        end
        ST_PUSH: begin
          cnt <= cnt + 3'h1;
          if (cnt == PUSH_LAST) begin
            state <= ST_VEC;
          end
        end
        ST_VEC: begin
          pcLoad    <= svcVec;
          pcLoadStb <= 1'b1;
          cpuHold   <= 1'b0;
          state     <= ST_RUN;
        end
        ST_POP: begin
          cnt <= cnt + 3'h1;
          if (cnt == PUSH_LAST) begin
            state <= ST_RET;
          end
        end
        ST_RET: begin
          pcLoad        <= {pchPop, stackMem[spReg]};
          pcLoadStb     <= 1'b1;
          ctxRestoreStb <= 1'b1;
          xRestore      <= xPop;
          aRestore      <= aPop;
          cpuHold       <= 1'b0;
          state         <= ST_RUN;
        end
        default: begin
          cpuHold <= 1'b0;
          state   <= ST_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // context stack
  // ****************************************
  always_comb begin
    unique case (cnt)
      3'h0:    pushByte = ctxPc[7:0];
      3'h1:    pushByte = ctxPc[15:8];
      3'h2:    pushByte = ctxX;
      3'h3:    pushByte = ctxA;
      default: pushByte = ctxCc;
    endcase
  end

  assign spPlus = spReg + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (state == ST_PUSH) begin
      stackMem[spReg] <= pushByte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spReg <= '1;
    end else if (state == ST_PUSH) begin
      spReg <= spReg - 1'b1;
    end else if (state == ST_POP) begin
      spReg <= spPlus;
    end
  end

  // last pop byte is read in ST_RET; pointer already on it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ccPop  <= CC_RESET;
      aPop   <= 8'h00;
      xPop   <= 8'h00;
      pchPop <= 8'h00;
    end else if (state == ST_POP) begin
      unique case (cnt)
        3'h0:    ccPop  <= stackMem[spPlus];
        3'h1:    aPop   <= stackMem[spPlus];
        3'h2:    xPop   <= stackMem[spPlus];
        3'h3:    pchPop <= stackMem[spPlus];
        default: ;
      endcase
    end
  end

  // ****************************************
  // priority pair and condition code view
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prioReg <= LVL3_CODE;
    end else if (state == ST_VEC) begin
      prioReg <= svcNmi ? LVL3_CODE : svcPrio;
    end else if (state == ST_RET) begin
      prioReg <= {ccPop[PRIO_HI_BIT], ccPop[PRIO_LO_BIT]};
    end else if (wrEn && address == OFS_CC) begin
      prioReg <= {writedata[PRIO_HI_BIT], writedata[PRIO_LO_BIT]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ccOut <= CC_RESET;
    end else begin
      ccOut <= ccCur;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  assign wrEn = write && !waitrequest;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int r = 0; r < 4; r++) begin
        isprReg[r] <= PRIO_RESET;
      end
      enReg     <= '0;
      extSelReg <= 8'h00;
    end else if (wrEn) begin
      for (int r = 0; r < 4; r++) begin
        if (address == OFS_PRIO0 + 5'(4 * r)) begin
          for (int p = 0; p < 4; p++) begin
            if (writedata[2*p+:2] != LVL0_CODE && !(r == 3 && p > 1)) begin
              isprReg[r][2*p+:2] <= writedata[2*p+:2];
            end
          end
        end
      end
      if (address == OFS_ENABLE) begin
        enReg <= writedata[NVEC-1:0] & MASKABLE;
      end
      if (address == OFS_EXTSEL) begin
        extSelReg <= writedata[7:0];
      end
    end
  end

  always_comb begin
    unique case (address)
      OFS_CC:      rdMux = {24'h000000, ccCur};
      OFS_PRIO0:   rdMux = {24'h000000, isprReg[0]};
      OFS_PRIO1:   rdMux = {24'h000000, isprReg[1]};
      OFS_PRIO2:   rdMux = {24'h000000, isprReg[2]};
      OFS_PRIO3:   rdMux = {24'h000000, isprReg[3]};
      OFS_ENABLE:  rdMux = {18'h00000, enReg};
      OFS_PENDING: rdMux = {18'h00000, pendReg[NVEC-1:1], tliPend};
      OFS_EXTSEL:  rdMux = {24'h000000, extSelReg};
      default:     rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= rdMux;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_nmi_lvl3;
    (state == ST_VEC && svcNmi) |=> prioReg == LVL3_CODE;
  endproperty
  a_nmi_lvl3: assert property (p_nmi_lvl3) else $error("nmi entry did not set level 3");

  property p_msk_prio;
    (state == ST_VEC && !svcNmi) |=> prioReg == $past(svcPrio);
  endproperty
  a_msk_prio: assert property (p_msk_prio) else $error("maskable entry level wrong");

  property p_stack_seq;
    take |=> (state == ST_PUSH) [*5] ##1 (state == ST_VEC) ##1 pcLoadStb;
  endproperty
  a_stack_seq: assert property (p_stack_seq) else $error("stacking sequence broken");

  property p_vec_load;
    (state == ST_VEC) |=> pcLoadStb && pcLoad == $past(svcVec) && !cpuHold;
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector not loaded");

  property p_ret_prio;
    (state == ST_RET) |=> prioReg == {$past(ccPop[PRIO_HI_BIT]), $past(ccPop[PRIO_LO_BIT])} && ctxRestoreStb;
  endproperty
  a_ret_prio: assert property (p_ret_prio) else $error("return did not restore level");

  property p_msk_above;
    mskTake |-> lvl_of(vecPair[arbIdx]) > lvl_of(prioReg) && enReg[arbIdx];
  endproperty
  a_msk_above: assert property (p_msk_above) else $error("maskable taken at or below level");

  property p_trap_guard;
    (run && trapActive && tliPend) |-> !tliTake;
  endproperty
  a_trap_guard: assert property (p_trap_guard) else $error("watchdog interrupt preempted trap");

  property p_tli_raise;
    (wdgFlag && !wdgPrev) |=> tliPend;
  endproperty
  a_tli_raise: assert property (p_tli_raise) else $error("watchdog flag did not raise request");

  property p_clr_drop;
    (periphClr != 0 && (setVec & periphClr) == 0) |=> (pendReg & $past(periphClr)) == 0;
  endproperty
  a_clr_drop: assert property (p_clr_drop) else $error("clear sequence left request pending");

  property p_sp_wrap;
    (state == ST_PUSH && spReg == '0) |=> spReg == '1;
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("stack pointer did not wrap");

  property p_halt_first;
    (mskTake && haltFirst) |-> HALT_CAP[arbIdx];
  endproperty
  a_halt_first: assert property (p_halt_first) else $error("non halt-capable served first after halt");

  c_trap: cover property (trapTake ##[1:200] iretTake);
  c_tli: cover property (tliTake);
  c_nest: cover property (mskTake ##[1:40] mskTake);
  c_halt_wake: cover property (haltMode && wakeReq);

endmodule : nested_priority_interrupt_ctrl

// [verilog/nic_pkg.sv]
package nic_pkg;

  // ****************************************
  // vector and level layout
  // ****************************************
  localparam int          NVEC        = 14;
  localparam int          EXT_VEC     = 2;
  localparam int          PRIO_HI_BIT = 5;
  localparam int          PRIO_LO_BIT = 3;
  localparam logic [1:0]  LVL0_CODE   = 2'h2;
  localparam logic [1:0]  LVL1_CODE   = 2'h1;
  localparam logic [1:0]  LVL2_CODE   = 2'h0;
  localparam logic [1:0]  LVL3_CODE   = 2'h3;
  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP    = 16'hFFFC;
  localparam logic [15:0] VEC_BASE    = 16'hFFFA;
  localparam logic [7:0]  PRIO_RESET  = 8'hFF;
  localparam logic [7:0]  CC_RESET    = 8'hEA;
  localparam logic [13:0] HALT_CAP_DEF = 14'h210E;
  localparam logic [13:0] MASKABLE    = 14'h3FFE;
  localparam logic [2:0]  PUSH_LAST   = 3'h4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [4:0] OFS_CC      = 5'h00;
  localparam logic [4:0] OFS_PRIO0   = 5'h04;
  localparam logic [4:0] OFS_PRIO1   = 5'h08;
  localparam logic [4:0] OFS_PRIO2   = 5'h0C;
  localparam logic [4:0] OFS_PRIO3   = 5'h10;
  localparam logic [4:0] OFS_ENABLE  = 5'h14;
  localparam logic [4:0] OFS_PENDING = 5'h18;
  localparam logic [4:0] OFS_EXTSEL  = 5'h1C;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN   = 3'b001,
    ST_PUSH  = 3'b010,
    ST_VEC   = 3'b011,
    ST_POP   = 3'b100,
    ST_RET   = 3'b101
  } seq_state_t;

  // code pair to numeric level, 0 lowest
  function automatic logic [1:0] lvl_of(input logic [1:0] code);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      LVL0_CODE: r = 2'h0;
      LVL1_CODE: r = 2'h1;
      LVL2_CODE: r = 2'h2;
      LVL3_CODE: r = 2'h3;
    endcase
    return r;
  endfunction : lvl_of

endpackage : nic_pkg

// [verilog/prio_arbiter.sv]
`timescale 1ns/1ns
module prio_arbiter #(
  parameter int N = 14
) (
  input  wire logic [N-1:0]   req,
  input  wire logic [2*N-1:0] lvl,
  output logic                found,
  output logic [3:0]          idx,
  output logic [1:0]          best
);

  // lower index is the higher fixed priority
  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    best  = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!found || lvl[2*i+:2] >= best)) begin
        found = 1'b1;
        idx   = 4'(i);
        best  = lvl[2*i+:2];
      end
    end
  end

endmodule : prio_arbiter
